// File: design/ris_reset_seq.sv
// Purpose: Reset initialisation sequencer: power-on config capture and timed reset release.
// Assumes: Board pull-ups on both reset lines; pins asynchronous to mclk.
// Notes:   Sync and primary clocks are sampled as pins, so they must run well below mclk/4.
`timescale 1ns/1ps
module ris_reset_seq #(
   parameter int unsigned PLL_WAIT_CYC = ris_pkg::PLL_LOCK_CYC,
   parameter int unsigned DLL_WAIT_CYC = ris_pkg::DLL_LOCK_MAX_CYC
) (
   // Clock and reset.
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   // Clock and mode pins.
   input  wire logic                 primary_clock_in,
   input  wire logic                 sync_clock_in,
   input  wire logic                 host_mode,
   // Power-on reset pin, low while asserted.
   input  wire logic                 power_on_reset_in_n,
   // Open-drain hard reset line.
   input  wire logic                 hard_reset_line_in,
   output logic                      hard_reset_line_out,
   output logic                      hard_reset_line_oe,
   // Open-drain soft reset line.
   input  wire logic                 soft_reset_line_in,
   output logic                      soft_reset_line_out,
   output logic                      soft_reset_line_oe,
   // Configuration pins, shared with a later output use.
   input  wire logic [3:0]           cfg_pin_in,
   output logic [3:0]                cfg_pin_out,
   output logic [3:0]                cfg_pin_oe,
   input  wire logic                 cfg_drive_req,
   input  wire logic [3:0]           cfg_drive_data,
   // Results.
   output ris_pkg::ris_por_cfg_t     por_cfg,
   output logic                      seq_done
);

   // Reset release synchroniser.
   logic rst_meta_r;
   logic rst_sync_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // All pins pass two flops before use.
   logic [ris_pkg::PIN_W-1:0] pins;
   logic [ris_pkg::PIN_W-1:0] lvl;
   logic [ris_pkg::PIN_W-1:0] rise;

   assign pins = {cfg_pin_in, host_mode, soft_reset_line_in, hard_reset_line_in,
                  power_on_reset_in_n, sync_clock_in, primary_clock_in};

   ris_pin_sync #(.W(ris_pkg::PIN_W)) u_sync (
      .mclk  (mclk),
      .rst_n (rst_sync_r),
      .pin   (pins),
      .level (lvl),
      .rise  (rise),
      .fall  ()
   );

   // State.
   ris_pkg::ris_state_t       state_r, state_nxt;
   logic [ris_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [ris_pkg::CNT_W-1:0] por_cnt_r, por_cnt_nxt;
   logic [ris_pkg::CNT_W-1:0] ext_cnt_r, ext_cnt_nxt;
   logic                      half_r, half_nxt;
   logic [1:0]                resume_r, resume_nxt;
   ris_pkg::ris_por_cfg_t     cfg_r, cfg_nxt;
   logic                      hard_oe_r, hard_oe_nxt;
   logic                      soft_oe_r, soft_oe_nxt;
   logic [3:0]                cfg_oe_r, cfg_oe_nxt;
   logic [3:0]                cfg_out_r, cfg_out_nxt;
   logic                      done_r, done_nxt;

   logic sync_tick;
   logic ref_tick;
   logic hard_low;
   logic ext_low;

   // Sync period: in host mode the primary clock divided by one or two.
   always_comb begin
      half_nxt = half_r ^ rise[ris_pkg::P_PRIM];
      if (lvl[ris_pkg::P_HOST]) begin
         sync_tick = rise[ris_pkg::P_PRIM] & (half_r | ~cfg_r.clk_div);
      end else begin
         sync_tick = rise[ris_pkg::P_SYNC];
      end
      // Power-on reset is timed on the primary clock in host mode only.
      ref_tick = lvl[ris_pkg::P_HOST] ? rise[ris_pkg::P_PRIM] : rise[ris_pkg::P_SYNC];
      hard_low = hard_oe_r | ~lvl[ris_pkg::P_HARD];
      ext_low  = ~lvl[ris_pkg::P_HARD] | ~lvl[ris_pkg::P_SOFT];
   end

   // Sequencer next state, counters and line drive.
   always_comb begin
      state_nxt   = state_r;
      cnt_nxt     = cnt_r;
      por_cnt_nxt = por_cnt_r;
      ext_cnt_nxt = ext_cnt_r;
      cfg_nxt     = cfg_r;
      hard_oe_nxt = hard_oe_r;
      soft_oe_nxt = soft_oe_r;
      done_nxt    = done_r;

      // Count power-on reset assertion in reference periods, saturating.
      if (lvl[ris_pkg::P_POR_N]) begin
         por_cnt_nxt = '0;
      end else if (ref_tick && por_cnt_r <= ris_pkg::IN_ASSERT_MIN) begin
         por_cnt_nxt = por_cnt_r + 1'b1;
      end

      case (state_r)
         ris_pkg::S_POR: begin
            hard_oe_nxt = 1'b1;
            soft_oe_nxt = 1'b1;
            done_nxt    = 1'b0;
            cnt_nxt     = '0;
            // Too short a pulse is ignored; the next assertion counts afresh.
            if (rise[ris_pkg::P_POR_N] && por_cnt_r > ris_pkg::IN_ASSERT_MIN) begin
               cfg_nxt.boot_src = lvl[ris_pkg::P_CFG_LSB + ris_pkg::CFG_BOOT_LSB +: 3];
               cfg_nxt.clk_div  = lvl[ris_pkg::P_CFG_LSB + ris_pkg::CFG_DIV_BIT];
               state_nxt        = ris_pkg::S_PLL;
            end
         end
         ris_pkg::S_PLL: begin
            if (cnt_r >= PLL_WAIT_CYC[ris_pkg::CNT_W-1:0] - 1'b1) begin
               cnt_nxt   = '0;
               state_nxt = ris_pkg::S_DLL;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         ris_pkg::S_DLL: begin
            if (cnt_r >= DLL_WAIT_CYC[ris_pkg::CNT_W-1:0] - 1'b1) begin
               cnt_nxt   = '0;
               state_nxt = ris_pkg::S_ASSERT;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         ris_pkg::S_ASSERT: begin
            hard_oe_nxt = 1'b1;
            soft_oe_nxt = 1'b1;
            done_nxt    = 1'b0;
            // One extra edge covers the partial period at entry.
            if (sync_tick) begin
               if (cnt_r == ris_pkg::OUT_ASSERT_MIN) begin
                  cnt_nxt     = '0;
                  hard_oe_nxt = 1'b0;
                  state_nxt   = ris_pkg::S_HREL;
               end else begin
                  cnt_nxt = cnt_r + 1'b1;
               end
            end
         end
         ris_pkg::S_HREL: begin
            if (sync_tick) begin
               if (cnt_r == ris_pkg::SOFT_LAG_MIN) begin
                  cnt_nxt     = '0;
                  soft_oe_nxt = 1'b0;
                  done_nxt    = 1'b1;
                  ext_cnt_nxt = '0;
                  state_nxt   = ris_pkg::S_RUN;
               end else begin
                  cnt_nxt = cnt_r + 1'b1;
               end
            end
         end
         ris_pkg::S_RUN: begin
            // An outside pull on either line restarts the output sequence.
            if (!ext_low) begin
               ext_cnt_nxt = '0;
            end else if (sync_tick) begin
               if (ext_cnt_r == ris_pkg::IN_ASSERT_MIN) begin
                  cnt_nxt     = '0;
                  hard_oe_nxt = 1'b1;
                  soft_oe_nxt = 1'b1;
                  done_nxt    = 1'b0;
                  state_nxt   = ris_pkg::S_ASSERT;
               end else begin
                  ext_cnt_nxt = ext_cnt_r + 1'b1;
               end
            end
         end
         default: begin
            state_nxt = ris_pkg::S_POR;
         end
      endcase

      // Power-on reset overrides everything, once seen on the clean copy.
      if (!lvl[ris_pkg::P_POR_N]) begin
         state_nxt   = ris_pkg::S_POR;
         hard_oe_nxt = 1'b1;
         soft_oe_nxt = 1'b1;
         done_nxt    = 1'b0;
      end
   end

   // Config pin drive: off while hard reset is low, back after a full sync period.
   always_comb begin
      resume_nxt  = resume_r;
      cfg_oe_nxt  = '0;
      cfg_out_nxt = cfg_drive_data;
      if (hard_low) begin
         resume_nxt = '0;
      end else if (sync_tick && resume_r != ris_pkg::CFG_RESUME_TICKS) begin
         resume_nxt = resume_r + 1'b1;
      end
      // Two edges after release guarantee one whole period has elapsed.
      if (!hard_low && !hard_oe_nxt && resume_r == ris_pkg::CFG_RESUME_TICKS) begin
         cfg_oe_nxt = {4{cfg_drive_req}};
      end
   end

   // Register all state.
   always_ff @(posedge mclk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         state_r   <= ris_pkg::S_POR;
         cnt_r     <= '0;
         por_cnt_r <= '0;
         ext_cnt_r <= '0;
         half_r    <= 1'b0;
         resume_r  <= 2'h0;
         cfg_r     <= ris_pkg::POR_CFG_RST;
         hard_oe_r <= 1'b1;
         soft_oe_r <= 1'b1;
         cfg_oe_r  <= 4'h0;
         cfg_out_r <= 4'h0;
         done_r    <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         cnt_r     <= cnt_nxt;
         por_cnt_r <= por_cnt_nxt;
         ext_cnt_r <= ext_cnt_nxt;
         half_r    <= half_nxt;
         resume_r  <= resume_nxt;
         cfg_r     <= cfg_nxt;
         hard_oe_r <= hard_oe_nxt;
         soft_oe_r <= soft_oe_nxt;
         cfg_oe_r  <= cfg_oe_nxt;
         cfg_out_r <= cfg_out_nxt;
         done_r    <= done_nxt;
      end
   end

   // Open-drain lines: data is a constant low, only the enable moves.
   assign hard_reset_line_out = 1'b0;
   assign soft_reset_line_out = 1'b0;
   assign hard_reset_line_oe  = hard_oe_r;
   assign soft_reset_line_oe  = soft_oe_r;
   assign cfg_pin_oe          = cfg_oe_r;
   assign cfg_pin_out         = cfg_out_r;
   assign por_cfg             = cfg_r;
   assign seq_done            = done_r;

endmodule // ris_reset_seq

// File: design/ris_pkg.sv
// Purpose: Shared constants and types for the reset initialisation sequencer.
// Assumes: Core clock mclk at 200 MHz; all pin inputs are asynchronous to it.
// Notes:   Counts in sync periods are counted in edges of the synchronisation clock.
// Overview of operation
// - Drive lines 512 periods; soft released 16 later.
// - Config pins released at hard reset; resume later.
// - Config is three boot bits plus divide bit.
// - Reset lines are open drain, only pulled low.
// - Host mode derives sync period from divide setting.
// - Wait 100 microseconds for clock lock.
// - Wait for delay-line lock, up to 122880 cycles.
package ris_pkg;

   // Core clock rate and lock timing.
   localparam int unsigned CLK_MHZ          = 200;
   localparam int unsigned PLL_LOCK_US      = 100;
   localparam int unsigned PLL_LOCK_CYC     = PLL_LOCK_US * CLK_MHZ;
   localparam int unsigned DLL_LOCK_MIN_CYC = 7680;
   localparam int unsigned DLL_LOCK_MAX_CYC = 122880;

   // Sequence counts, in synchronisation clock periods.
   localparam int unsigned CNT_W            = 20;
   localparam logic [CNT_W-1:0] IN_ASSERT_MIN  = 20'h00020;
   localparam logic [CNT_W-1:0] OUT_ASSERT_MIN = 20'h00200;
   localparam logic [CNT_W-1:0] SOFT_LAG_MIN   = 20'h00010;
   localparam logic [1:0]       CFG_RESUME_TICKS = 2'h2;

   // Synchronised pin vector layout.
   localparam int unsigned PIN_W      = 10;
   localparam int unsigned P_PRIM     = 0;
   localparam int unsigned P_SYNC     = 1;
   localparam int unsigned P_POR_N    = 2;
   localparam int unsigned P_HARD     = 3;
   localparam int unsigned P_SOFT     = 4;
   localparam int unsigned P_HOST     = 5;
   localparam int unsigned P_CFG_LSB  = 6;

   // Configuration pin field layout.
   localparam int unsigned CFG_W        = 4;
   localparam int unsigned CFG_BOOT_LSB = 0;
   localparam int unsigned CFG_DIV_BIT  = 3;

   // Latched power-on configuration.
   typedef struct packed {
      logic [2:0] boot_src;
      logic       clk_div;
   } ris_por_cfg_t;

   localparam ris_por_cfg_t POR_CFG_RST = '{boot_src: 3'h0, clk_div: 1'b0};

   // Sequencer states.
   typedef enum logic [2:0] {
      S_POR,
      S_PLL,
      S_DLL,
      S_ASSERT,
      S_HREL,
      S_RUN
   } ris_state_t;

endpackage

// File: design/ris_pin_sync.sv
// Purpose: Two-stage synchroniser for a vector of pins, with edge pulses.
// Assumes: Pins are asynchronous to mclk; rst_n is already synchronised.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module ris_pin_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset.
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // Raw pins.
   input  wire logic [W-1:0] pin,
   // Synchronised level and edges.
   output logic [W-1:0]      level,
   output logic [W-1:0]      rise,
   output logic [W-1:0]      fall
);

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] last_r;

   // Two flops per pin, plus a third for edge detection off the clean copy.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
         last_r <= '0;
      end else begin
         meta_r <= pin;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   // Edges compare the clean copy with its delayed value.
   assign level = sync_r;
   assign rise  = sync_r & ~last_r;
   assign fall  = ~sync_r & last_r;

endmodule // ris_pin_sync

// File: verification/ris_reset_seq_checker.sv
// Purpose: Port-level checks of the reset sequencer.
// Assumes: The sync clock runs well below mclk/4.
// Notes:   Ticks are raw sync edges seen through two flops, so bounds are lower limits.
`timescale 1ns/1ps
module ris_reset_seq_checker (
   // Clock and reset.
   input wire logic                  mclk,
   input wire logic                  rst_n,
   // Pins.
   input wire logic                  sync_clock_in,
   input wire logic                  power_on_reset_in_n,
   input wire logic                  hard_reset_line_in,
   input wire logic                  hard_reset_line_out,
   input wire logic                  hard_reset_line_oe,
   input wire logic                  soft_reset_line_in,
   input wire logic                  soft_reset_line_out,
   input wire logic                  soft_reset_line_oe,
   input wire logic [3:0]            cfg_pin_in,
   input wire logic [3:0]            cfg_pin_out,
   input wire logic [3:0]            cfg_pin_oe,
   input wire logic                  cfg_drive_req,
   input wire logic [3:0]            cfg_drive_data,
   // Results.
   input wire ris_pkg::ris_por_cfg_t por_cfg,
   input wire logic                  seq_done
);
   logic [2:0]  sy_r;
   logic [11:0] asrt_r, rel_r, hi_r, ext_r;
   logic        tk;
   assign tk = sy_r[1] & ~sy_r[2];
   // Tick counters; each holds at zero outside its window and counts ticks inside it.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sy_r   <= 3'h0;
         asrt_r <= 12'h000;
         rel_r  <= 12'h000;
         hi_r   <= 12'h000;
         ext_r  <= 12'h000;
      end else begin
         sy_r   <= {sy_r[1:0], sync_clock_in};
         asrt_r <= !hard_reset_line_oe ? 12'h000 : asrt_r + 12'(tk);
         rel_r  <= hard_reset_line_oe ? 12'h000 : rel_r + 12'(tk);
         hi_r   <= !hard_reset_line_in ? 12'h000 : hi_r + 12'(tk);
         ext_r  <= ((hard_reset_line_in && soft_reset_line_in) || hard_reset_line_oe) ?
                   12'h000 : ext_r + 12'(tk);
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   od_pins_a: assert property (!hard_reset_line_out && !soft_reset_line_out)
      else $error("reset line driven high");
   hold_min_a: assert property ($fell(hard_reset_line_oe) |-> asrt_r >= 12'h200)
      else $error("hard reset released early");
   lag_min_a: assert property ($fell(soft_reset_line_oe) |-> rel_r >= 12'h010)
      else $error("soft reset released too soon after hard");
   done_soft_a: assert property ($rose(seq_done) |-> $fell(soft_reset_line_oe))
      else $error("done not tied to soft release");
   cfg_off_a: assert property (hard_reset_line_oe |=> cfg_pin_oe == 4'h0)
      else $error("config pins driven during hard reset");
   cfg_on_a: assert property ($rose(cfg_pin_oe[0]) |-> hi_r >= 12'h001 && $past(cfg_drive_req))
      else $error("config pins driven too early");
   cfg_data_a: assert property (cfg_pin_oe[0] |-> cfg_pin_out == $past(cfg_drive_data))
      else $error("config drive data wrong");
   por_latch_a: assert property (!$stable(por_cfg) |-> power_on_reset_in_n &&
      por_cfg.boot_src == cfg_pin_in[2:0] && por_cfg.clk_div == cfg_pin_in[3])
      else $error("power-on config latched wrongly");
   por_force_a: assert property (!power_on_reset_in_n |-> ##[1:5]
      (hard_reset_line_oe && soft_reset_line_oe && !seq_done))
      else $error("power-on reset did not force lines");
   ext_min_a: assert property ($rose(hard_reset_line_oe) && power_on_reset_in_n |->
      ext_r >= 12'h020)
      else $error("external reset accepted too soon");
endmodule // ris_reset_seq_checker

bind ris_reset_seq ris_reset_seq_checker u_chk (.mclk(mclk), .rst_n(rst_n),
   .sync_clock_in(sync_clock_in), .power_on_reset_in_n(power_on_reset_in_n),
   .hard_reset_line_in(hard_reset_line_in), .hard_reset_line_out(hard_reset_line_out),
   .hard_reset_line_oe(hard_reset_line_oe), .soft_reset_line_in(soft_reset_line_in),
   .soft_reset_line_out(soft_reset_line_out), .soft_reset_line_oe(soft_reset_line_oe),
   .cfg_pin_in(cfg_pin_in), .cfg_pin_out(cfg_pin_out), .cfg_pin_oe(cfg_pin_oe),
   .cfg_drive_req(cfg_drive_req), .cfg_drive_data(cfg_drive_data), .por_cfg(por_cfg),
   .seq_done(seq_done));

// File: verification/ris_board.sv
// Purpose: Board model: clocks, power-on reset, external hard reset pull, config straps.
// Assumes: Both reset lines and the straps are pulled up on the board.
// Notes:   In host mode the sync clock is the primary clock divided by the divide strap.
`timescale 1ns/1ps
module ris_board (
   // Requests from the bench.
   input wire logic       host_mode,
   input wire logic       por_req,
   input wire logic       ext_req,
   input wire logic [7:0] ext_len,
   input wire logic [3:0] cfg_strap,
   // Device drive.
   input wire logic       hard_oe,
   input wire logic       hard_out,
   input wire logic       soft_oe,
   input wire logic       soft_out,
   input wire logic [3:0] cfg_oe,
   input wire logic [3:0] cfg_out,
   // Pin levels.
   output logic           primary_clock_in,
   output logic           sync_clock_in,
   output logic           power_on_reset_in_n,
   output logic           hard_in,
   output logic           soft_in,
   output logic [3:0]     cfg_in
);
   logic       pc = 1'b0;
   logic       ac = 1'b0;
   logic       dc = 1'b0;
   logic [7:0] por_c = 8'h00;
   logic [7:0] ext_c = 8'h00;
   logic [3:0] strap = 4'hf;
   logic       ref_clk;
   // Free-running clocks; the host sync clock follows the divide strap.
   always #20 pc = ~pc;
   always #24 ac = ~ac;
   always @(posedge pc) dc <= strap[3] ? ~dc : 1'b0;
   assign primary_clock_in = pc;
   assign sync_clock_in = host_mode ? (strap[3] ? dc : pc) : ac;
   assign ref_clk = host_mode ? pc : sync_clock_in;
   // Power-on reset held 40 reference periods; straps change only as it asserts.
   always @(posedge ref_clk) begin
      if (por_req && por_c == 8'h00) begin
         por_c <= 8'h28;
         strap <= cfg_strap;
      end else if (por_c != 8'h00) begin
         por_c <= por_c - 8'h01;
      end
   end
   // External hard reset pull for the requested number of sync periods.
   always @(posedge sync_clock_in) begin
      if (ext_req && ext_c == 8'h00) begin
         ext_c <= ext_len;
      end else if (ext_c != 8'h00) begin
         ext_c <= ext_c - 8'h01;
      end
   end
   // Open-drain wires with pull-ups; released straps read back as strapped.
   assign power_on_reset_in_n = (por_c == 8'h00);
   assign hard_in = !((hard_oe && !hard_out) || ext_c != 8'h00);
   assign soft_in = !(soft_oe && !soft_out);
   assign cfg_in = (cfg_oe & cfg_out) | (~cfg_oe & strap);
endmodule // ris_board

// File: verification/ris_reset_seq_test.sv
// Purpose: Self-checking bench for the reset sequencer.
// Assumes: Lock waits shortened to 20 and 30 mclk cycles.
// Notes:   Timing checks allow one tick of slack for pin synchronisation.
`timescale 1ns/1ps
module ris_reset_seq_test;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic host_mode = 1'b0;
   logic por_req = 1'b0;
   logic ext_req = 1'b0;
   logic [7:0] ext_len = 8'h00;
   logic [3:0] cfg_strap = 4'h0;
   logic cfg_drive_req = 1'b0;
   logic [3:0] cfg_drive_data = 4'h0;
   logic prim, sync, por_n, hard_in, hard_out, hard_oe, soft_in, soft_out, soft_oe, seq_done;
   logic [3:0] cfg_in, cfg_out, cfg_oe;
   ris_pkg::ris_por_cfg_t por_cfg;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int sn = 0;
   ris_reset_seq #(.PLL_WAIT_CYC(20), .DLL_WAIT_CYC(30)) u_ris_reset_seq (.mclk(mclk),
      .rst_n(rst_n), .primary_clock_in(prim), .sync_clock_in(sync), .host_mode(host_mode),
      .power_on_reset_in_n(por_n), .hard_reset_line_in(hard_in), .hard_reset_line_out(hard_out),
      .hard_reset_line_oe(hard_oe), .soft_reset_line_in(soft_in), .soft_reset_line_out(soft_out),
      .soft_reset_line_oe(soft_oe), .cfg_pin_in(cfg_in), .cfg_pin_out(cfg_out), .cfg_pin_oe(cfg_oe),
      .cfg_drive_req(cfg_drive_req), .cfg_drive_data(cfg_drive_data), .por_cfg(por_cfg),
      .seq_done(seq_done));
   ris_board u_ris_board (.host_mode(host_mode), .por_req(por_req), .ext_req(ext_req),
      .ext_len(ext_len), .cfg_strap(cfg_strap), .hard_oe(hard_oe), .hard_out(hard_out),
      .soft_oe(soft_oe), .soft_out(soft_out), .cfg_oe(cfg_oe), .cfg_out(cfg_out),
      .primary_clock_in(prim), .sync_clock_in(sync), .power_on_reset_in_n(por_n),
      .hard_in(hard_in), .soft_in(soft_in), .cfg_in(cfg_in));
   // Clock, sync edge count and hang guard sized at about three times the run.
   always #2.5 mclk = ~mclk;
   always @(posedge sync) sn++;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 80000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Power-on reset in one mode; p is the sync period in ns, so the lag is timed.
   task automatic run_por(input logic h, input logic [3:0] s, input int p);
      int t0;
      host_mode <= h;
      cfg_strap <= s;
      por_req <= 1'b1;
      while (por_n) @(posedge mclk);
      por_req <= 1'b0;
      repeat (6) @(posedge mclk);
      check_eq(16'({hard_oe, soft_oe, seq_done}), 16'h6);
      while (!por_n) @(posedge mclk);
      while (hard_oe) @(posedge mclk);
      t0 = cyc;
      while (soft_oe) @(posedge mclk);
      check_eq(16'(por_cfg), 16'({s[2:0], s[3]}));
      check_eq(16'(cyc - t0 >= 16 * p / 5 && cyc - t0 <= 18 * p / 5), 16'h1);
   endtask
   // External hard reset pulse; only 33 ticks or more restarts the sequence.
   task automatic run_ext(input logic [7:0] len);
      int e0;
      logic acc;
      acc = len > 8'h20;
      cfg_drive_req <= 1'b1;
      cfg_drive_data <= len[3:0] ^ 4'ha;
      repeat (40) @(posedge mclk);
      check_eq(16'({cfg_oe, cfg_in}), 16'({4'hf, len[3:0] ^ 4'ha}));
      ext_len <= len;
      ext_req <= 1'b1;
      while (hard_in) @(posedge mclk);
      ext_req <= 1'b0;
      while (!hard_oe && !hard_in) @(posedge mclk);
      e0 = sn;
      check_eq(16'({hard_oe, cfg_oe}), 16'({acc, 4'h0}));
      while (hard_oe) @(posedge mclk);
      if (acc) check_eq(16'(sn - e0 >= 512 && sn - e0 <= 514), 16'h1);
      while (soft_oe) @(posedge mclk);
      repeat (40) @(posedge mclk);
      check_eq(16'({cfg_oe, seq_done}), 16'h1f);
      cfg_drive_req <= 1'b0;
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      run_por(1'b0, 4'hd, 48);
      run_ext(8'h14);
      run_ext(8'h28);
      run_por(1'b1, 4'h2, 40);
      run_por(1'b1, 4'h9, 80);
      end_of_test();
   end
endmodule // ris_reset_seq_test
